// [tcc_cmd.sv]
// command packet interpreter of a resistive touch screen controller
// Functional notes
// - calibrate: size 2, code 14h, type 1..4 picks 4, 9, 25 or 4 points
// - one reply per point after press and lift, size 2, echo 14h
// - register fetch reply: size N+2, status, 20h, N values ascending
// - register store: code 21h, addr, values; reply size 2, echo 21h
// - nonvolatile fetch reply: size N+2, status, 28h, N stored bytes
// - nonvolatile store: code 29h, addr, data bytes; reply size 2, 29h
// - code 23h size 1 loads parameter set from store into working RAM
// - code 2Bh copies working parameter set into the store
// - code 70h selects vendor HID type
// - low-level commands accepted only while vendor HID type is selected
// - type selection commands never produce a reply
// - code 71h size 1 selects pointer HID type
// - code 72h size 1 selects pen HID type
// - packets open with sync 55h then size of data section
// - packet unfinished after 250 ms is dropped and parser restarts
// - status codes 00h, 01h, 04h, 05h, FCh
// - reply command byte equals the received command byte, except calibration cancel which carries 14h
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defines.svh"
module tcc_cmd #(
    parameter int unsigned TIMEOUT_CYC =
        `TCC_PKT_TIMEOUT_MS * (`TCC_CLK_HZ / 1000)
) (
    input wire logic mclk_i,        // system clock
    input wire logic rst_i,         // async reset, active high
    input wire logic [7:0] rx_data_i, // command byte from link
    input wire logic rx_valid_i,    // command byte present
    output logic rx_ready_o,        // command byte taken
    output logic [7:0] tx_data_o,   // reply byte to link
    output logic tx_valid_o,        // reply byte present
    input wire logic tx_ready_i,    // link takes reply byte
    input wire logic touch_i,       // panel touched, pin
    input wire logic nvm_fault_i,   // store read failure, pin
    output logic [1:0] hid_type_o,  // default usb device type
    output logic touch_en_o,        // touch reporting enabled
    output logic cal_active_o,      // calibration running
    output logic [2:0] cal_type_o   // calibration type
);
    ////////////////////////////////////////////////////////////////////
    tcc_pkg::tcc_state_s r_reg, r_next;
    logic push, pop, acc, exec, gen, can_push;
    logic [7:0] pbyte, wa;

    function automatic tcc_pkg::tcc_state_s rep(
        input tcc_pkg::tcc_state_s s,
        input logic [7:0] stat,
        input logic [7:0] cmd,
        input logic [7:0] size,
        input tcc_pkg::tcc_src_e src
    );
        tcc_pkg::tcc_state_s o;
        o = s;
        o.st = tcc_pkg::ST_REPLY;
        o.rstat = stat;
        o.rcmd = cmd;
        o.rsize = size;
        o.rsrc = src;
        o.ridx = 8'h00;
        return o;
    endfunction : rep

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        r_next = r_reg;
        push = 1'b0;
        pbyte = 8'h00;
        exec = 1'b0;
        r_next.t1 = touch_i;
        r_next.t2 = r_reg.t1;
        r_next.f1 = nvm_fault_i;
        r_next.f2 = r_reg.f1;
        pop = r_reg.vld && tx_ready_i;
        can_push = (r_reg.bcnt != 2'd2) || pop;
        acc = r_reg.rx_rdy && rx_valid_i;
        gen = r_reg.hid == tcc_pkg::VENDOR_HID;
        wa = 8'(r_reg.alo + r_reg.cnt - `TCC_SZ_WRITE_MIN);
        case (r_reg.st)
            tcc_pkg::ST_RX:
            begin
                if (r_reg.pst != tcc_pkg::P_SYNC)
                    r_next.tmr = 24'(r_reg.tmr + 24'h1);
                if (acc)
                begin
                    case (r_reg.pst)
                        tcc_pkg::P_SYNC:
                        begin
                            if (rx_data_i == `TCC_SYNC)
                            begin
                                r_next.pst = tcc_pkg::P_SIZE;
                                r_next.tmr = 24'h0;
                                r_next.cmd = 8'h00;
                            end
                        end
                        tcc_pkg::P_SIZE:
                        begin
                            r_next.sz = rx_data_i;
                            r_next.cnt = 8'h00;
                            r_next.pst = (rx_data_i == 8'h00) ?
                                tcc_pkg::P_SYNC : tcc_pkg::P_DATA;
                        end
                        tcc_pkg::P_DATA:
                        begin
                            case (r_reg.cnt)
                                8'h00: r_next.cmd = rx_data_i;
                                8'h01: r_next.ahi = rx_data_i;
                                8'h02: r_next.alo = rx_data_i;
                                8'h03: r_next.nrq = rx_data_i;
                                default: ;
                            endcase
                            if (r_reg.cnt >= `TCC_SZ_WRITE_MIN && gen &&
                                r_reg.ahi == 8'h00 &&
                                r_reg.cmd == `TCC_CMD_REG_STORE)
                                r_next.regs[wa[3:0]] = rx_data_i;
                            if (r_reg.cnt >= `TCC_SZ_WRITE_MIN && gen &&
                                r_reg.ahi == 8'h00 &&
                                r_reg.cmd == `TCC_CMD_NVM_STORE)
                                r_next.nvm[wa[4:0]] = rx_data_i;
                            r_next.cnt = 8'(r_reg.cnt + 8'h01);
                            if (8'(r_reg.cnt + 8'h01) == r_reg.sz)
                            begin
                                exec = 1'b1;
                                r_next.pst = tcc_pkg::P_SYNC;
                            end
                        end
                        default: r_next.pst = tcc_pkg::P_SYNC;
                    endcase
                end
                else if (r_reg.pst != tcc_pkg::P_SYNC &&
                         r_reg.tmr == 24'(TIMEOUT_CYC - 1))
                begin
                    r_next.pst = tcc_pkg::P_SYNC;
                    if (gen)
                        r_next = rep(r_next, `TCC_ST_TIMEOUT, r_reg.cmd,
                                     `TCC_SZ_TWO, tcc_pkg::SRC_NONE);
                end
                if (exec)
                begin
                    if (r_next.cmd == `TCC_CMD_SEL_VENDOR ||
                        r_next.cmd == `TCC_CMD_SEL_POINTER ||
                        r_next.cmd == `TCC_CMD_SEL_PEN)
                    begin
                        if (r_reg.sz == `TCC_SZ_ONE)
                            r_next.hid = (r_next.cmd == `TCC_CMD_SEL_VENDOR) ?
                                tcc_pkg::VENDOR_HID :
                                (r_next.cmd == `TCC_CMD_SEL_POINTER) ?
                                tcc_pkg::POINTER_HID : tcc_pkg::PEN_HID;
                    end
                    // other commands only in vendor type
                    else if (gen)
                    begin
                        r_next = rep(r_next, `TCC_ST_UNKNOWN, r_next.cmd,
                                     `TCC_SZ_TWO, tcc_pkg::SRC_NONE);
                        case (r_next.cmd)
                            `TCC_CMD_TOUCH_EN, `TCC_CMD_TOUCH_DIS:
                                if (r_reg.sz == `TCC_SZ_ONE)
                                begin
                                    r_next.touch_en =
                                        r_next.cmd == `TCC_CMD_TOUCH_EN;
                                    r_next.rstat = `TCC_ST_OK;
                                end
                            `TCC_CMD_CAL:
                                if (r_reg.sz == `TCC_SZ_TWO &&
                                    r_next.ahi >= 8'h01 &&
                                    r_next.ahi <= 8'h04)
                                begin
                                    r_next.st = tcc_pkg::ST_CAL;
                                    r_next.cal = 1'b1;
                                    r_next.pressed = 1'b0;
                                    r_next.cal_type = r_next.ahi[2:0];
                                    r_next.pts = (r_next.ahi == 8'h02) ?
                                        `TCC_CAL_PTS_9 :
                                        (r_next.ahi == 8'h03) ?
                                        `TCC_CAL_PTS_25 : `TCC_CAL_PTS_4;
                                end
                            `TCC_CMD_REG_FETCH, `TCC_CMD_NVM_FETCH:
                                if (r_reg.sz == `TCC_SZ_FETCH &&
                                    r_next.ahi == 8'h00 &&
                                    r_next.nrq <= `TCC_MAX_FETCH)
                                begin
                                    r_next.rstat = `TCC_ST_OK;
                                    r_next.rsize =
                                        8'(r_next.nrq + `TCC_SZ_TWO);
                                    r_next.raddr = r_next.alo;
                                    r_next.rsrc =
                                        (r_next.cmd == `TCC_CMD_REG_FETCH) ?
                                        tcc_pkg::SRC_REG : tcc_pkg::SRC_NVM;
                                end
                            `TCC_CMD_REG_STORE, `TCC_CMD_NVM_STORE:
                                if (r_next.ahi == 8'h00 &&
                                    r_reg.sz >= `TCC_SZ_WRITE_MIN)
                                    r_next.rstat = `TCC_ST_OK;
                            `TCC_CMD_PARAM_LOAD:
                                if (r_reg.sz == `TCC_SZ_ONE)
                                begin
                                    r_next.rstat = r_reg.f2 ?
                                        `TCC_ST_LOAD_FAIL : `TCC_ST_OK;
                                    if (!r_reg.f2)
                                        r_next.regs =
                                            r_reg.nvm[`TCC_REG_WORDS-1:0];
                                end
                            `TCC_CMD_PARAM_SAVE:
                                if (r_reg.sz == `TCC_SZ_ONE)
                                begin
                                    r_next.rstat = `TCC_ST_OK;
                                    r_next.nvm[`TCC_REG_WORDS-1:0] =
                                        r_reg.regs;
                                end
                            default: ;
                        endcase
                    end
                end
            end
            tcc_pkg::ST_REPLY:
            begin
                if (can_push)
                begin
                    push = 1'b1;
                    case (r_reg.ridx)
                        8'h00: pbyte = `TCC_SYNC;
                        8'h01: pbyte = r_reg.rsize;
                        8'h02: pbyte = r_reg.rstat;
                        8'h03: pbyte = r_reg.rcmd;
                        default: pbyte = (r_reg.rsrc == tcc_pkg::SRC_REG) ?
                            r_reg.regs[r_reg.raddr[3:0]] :
                            r_reg.nvm[r_reg.raddr[4:0]];
                    endcase
                    if (r_reg.ridx > 8'h03)
                        r_next.raddr = 8'(r_reg.raddr + 8'h01);
                    r_next.ridx = 8'(r_reg.ridx + 8'h01);
                    if (r_reg.ridx == 8'(r_reg.rsize + 8'h01))
                        r_next.st = r_reg.cal ? tcc_pkg::ST_CAL :
                                                tcc_pkg::ST_RX;
                end
            end
            tcc_pkg::ST_CAL:
            begin
                if (acc)
                begin
                    r_next.cal = 1'b0;
                    r_next.pts = 5'h00;
                    r_next = rep(r_next, `TCC_ST_CAL_CANCEL, `TCC_CMD_CAL,
                                 `TCC_SZ_TWO, tcc_pkg::SRC_NONE);
                end
                else if (!r_reg.pressed && r_reg.t2)
                    r_next.pressed = 1'b1;
                else if (r_reg.pressed && !r_reg.t2)
                begin
                    r_next.pressed = 1'b0;
                    r_next.pts = 5'(r_reg.pts - 5'h01);
                    r_next.cal = r_reg.pts != 5'h01;
                    r_next = rep(r_next, `TCC_ST_OK, `TCC_CMD_CAL,
                                 `TCC_SZ_TWO, tcc_pkg::SRC_NONE);
                end
            end
            default: r_next.st = tcc_pkg::ST_RX;
        endcase
        r_next.rx_rdy = r_next.st != tcc_pkg::ST_REPLY;
        if (pop)
        begin
            r_next.b0 = r_reg.b1;
            r_next.bcnt = 2'(r_reg.bcnt - 2'd1);
        end
        if (push)
        begin
            if (r_next.bcnt == 2'd0)
                r_next.b0 = pbyte;
            else
                r_next.b1 = pbyte;
            r_next.bcnt = 2'(r_next.bcnt + 2'd1);
        end
        r_next.vld = r_next.bcnt != 2'd0;
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    assign rx_ready_o = r_reg.rx_rdy;
    assign tx_data_o = r_reg.b0;
    assign tx_valid_o = r_reg.vld;
    assign hid_type_o = r_reg.hid;
    assign touch_en_o = r_reg.touch_en;
    assign cal_active_o = r_reg.cal;
    assign cal_type_o = r_reg.cal_type;

    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    AST_SYNC_FIRST: assert property (
        push && r_reg.ridx == 8'h00 |-> pbyte == `TCC_SYNC)
        else $error("reply does not open with sync");
    AST_ECHO: assert property (
        push && r_reg.ridx == 8'h03 && !r_reg.cal && r_reg.rstat !=
        `TCC_ST_CAL_CANCEL |-> pbyte == r_reg.cmd)
        else $error("reply command byte not echoed");
    AST_SILENT_SEL: assert property (
        exec && r_next.cmd >= `TCC_CMD_SEL_VENDOR &&
        r_next.cmd <= `TCC_CMD_SEL_PEN |=> r_reg.st == tcc_pkg::ST_RX)
        else $error("type selection produced a reply");
    AST_PEN_SEL: assert property (
        exec && r_next.cmd == `TCC_CMD_SEL_PEN && r_reg.sz == 8'h01
        |=> hid_type_o == 2'(tcc_pkg::PEN_HID))
        else $error("pen type not selected");
    AST_GATE: assert property (
        exec && !gen && r_next.cmd == `TCC_CMD_REG_FETCH
        |=> r_reg.st == tcc_pkg::ST_RX)
        else $error("low-level command served outside vendor type");
    AST_TIMEOUT: assert property (
        r_reg.st == tcc_pkg::ST_RX && r_reg.pst != tcc_pkg::P_SYNC &&
        !acc && r_reg.tmr == 24'(TIMEOUT_CYC - 1)
        |=> r_reg.pst == tcc_pkg::P_SYNC)
        else $error("partial packet not dropped");
    AST_CAL_SIZE: assert property (
        push && r_reg.ridx == 8'h01 && r_reg.rcmd == `TCC_CMD_CAL
        |-> pbyte == `TCC_SZ_TWO)
        else $error("calibration reply size wrong");
    AST_FETCH_SIZE: assert property (
        exec && gen && r_next.cmd == `TCC_CMD_REG_FETCH &&
        r_reg.sz == 8'h04 && r_next.ahi == 8'h00 && r_next.nrq < 8'hfd
        |=> r_reg.rsize == 8'($past(r_next.nrq) + 8'h02))
        else $error("fetch reply size not count plus two");
    AST_UNKNOWN: assert property (
        exec && gen && r_next.cmd == 8'h30 |=> r_reg.rstat ==
        `TCC_ST_UNKNOWN && $stable(r_reg.regs))
        else $error("unknown command not reported");
    AST_HOLD: assert property (
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("reply byte changed while stalled");
endmodule : tcc_cmd
`default_nettype wire

// [tcc_defines.svh]
// constants of the touch controller command interpreter
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH
`define TCC_SYNC 8'h55
`define TCC_CMD_TOUCH_EN 8'h12
`define TCC_CMD_TOUCH_DIS 8'h13
`define TCC_CMD_CAL 8'h14
`define TCC_CMD_REG_FETCH 8'h20
`define TCC_CMD_REG_STORE 8'h21
`define TCC_CMD_PARAM_LOAD 8'h23
`define TCC_CMD_NVM_FETCH 8'h28
`define TCC_CMD_NVM_STORE 8'h29
`define TCC_CMD_PARAM_SAVE 8'h2b
`define TCC_CMD_SEL_VENDOR 8'h70
`define TCC_CMD_SEL_POINTER 8'h71
`define TCC_CMD_SEL_PEN 8'h72
`define TCC_ST_OK 8'h00
`define TCC_ST_UNKNOWN 8'h01
`define TCC_ST_TIMEOUT 8'h04
`define TCC_ST_LOAD_FAIL 8'h05
`define TCC_ST_CAL_CANCEL 8'hfc
`define TCC_SZ_ONE 8'h01
`define TCC_SZ_TWO 8'h02
`define TCC_SZ_FETCH 8'h04
`define TCC_SZ_WRITE_MIN 8'h03
`define TCC_MAX_FETCH 8'hfd
`define TCC_CAL_PTS_4 5'h04
`define TCC_CAL_PTS_9 5'h09
`define TCC_CAL_PTS_25 5'h19
`define TCC_REG_WORDS 16
`define TCC_NVM_WORDS 32
`define TCC_CLK_HZ 50000000
`define TCC_PKT_TIMEOUT_MS 250
`endif

// [tcc_host_sink.sv]
// host side model: takes reply bytes, stalling now and then
`timescale 1ns/1ps
`default_nettype none
module tcc_host_sink (
    input wire logic mclk_i, // system clock
    input wire logic rst_i, // async reset
    input wire logic [7:0] tx_data_i, // reply byte
    input wire logic tx_valid_i, // reply byte present
    output logic tx_ready_o, // host takes byte
    output logic got_o, // byte was taken
    output logic [7:0] byte_o // byte taken
);
    logic [3:0] cnt_reg;
    initial tx_ready_o = 1'b0;
    // stalls two cycles of eight, changed off the sampling edge
    always @(negedge mclk_i)
        tx_ready_o <= !rst_i && (cnt_reg[2:1] != 2'b11);
    // keeps reply bytes whole and in order
    always_ff @(posedge mclk_i or posedge rst_i)
        if (rst_i)
        begin
            cnt_reg <= 4'h0;
            got_o <= 1'b0;
            byte_o <= 8'h00;
        end
        else
        begin
            cnt_reg <= cnt_reg + 4'h1;
            got_o <= tx_valid_i && tx_ready_o;
            byte_o <= tx_data_i;
        end
endmodule : tcc_host_sink
`default_nettype wire

// [tcc_pkg.sv]
// types of the touch controller command interpreter
`include "tcc_defines.svh"
package tcc_pkg;
    typedef enum logic [1:0] {ST_RX, ST_REPLY, ST_CAL} tcc_st_e;
    typedef enum logic [1:0] {P_SYNC, P_SIZE, P_DATA} tcc_pst_e;
    typedef enum logic [1:0] {VENDOR_HID, POINTER_HID, PEN_HID} tcc_hid_e;
    typedef enum logic [1:0] {SRC_NONE, SRC_REG, SRC_NVM} tcc_src_e;
    typedef struct packed {
        tcc_st_e st;
        tcc_pst_e pst;
        logic [7:0] sz;
        logic [7:0] cnt;
        logic [7:0] cmd;
        logic [7:0] ahi;
        logic [7:0] alo;
        logic [7:0] nrq;
        logic [23:0] tmr;
        logic rx_rdy;
        tcc_hid_e hid;
        logic touch_en;
        logic cal;
        logic [2:0] cal_type;
        logic [4:0] pts;
        logic pressed;
        logic [7:0] rstat;
        logic [7:0] rcmd;
        logic [7:0] rsize;
        tcc_src_e rsrc;
        logic [7:0] raddr;
        logic [7:0] ridx;
        logic [7:0] b0;
        logic [7:0] b1;
        logic [1:0] bcnt;
        logic vld;
        logic t1;
        logic t2;
        logic f1;
        logic f2;
        logic [`TCC_REG_WORDS-1:0][7:0] regs;
        logic [`TCC_NVM_WORDS-1:0][7:0] nvm;
    } tcc_state_s;
endpackage : tcc_pkg

// [tcc_tb.sv]
// self-checking testbench of the command interpreter
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef logic [7:0] tcc_b_t;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic rx_valid_i = 1'b0;
    logic touch_i = 1'b0;
    logic nvm_fault_i = 1'b0;
    logic [7:0] rx_data_i = 8'h00;
    wire rx_ready_o, tx_valid_o, tx_ready_i, got, ten, cact;
    wire [7:0] tx_data_o, gb;
    wire [1:0] hid;
    wire [2:0] ctyp;
    int miscompares = 0;
    int comparisons = 0;
    logic [31:0] seed = 32'h5bb87df5;
    tcc_b_t mdl [48];
    tcc_b_t rxq [$];
    tcc_cmd #(.TIMEOUT_CYC(200)) dut_u (.mclk_i(mclk_i), .rst_i(rst_i),
        .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i),
        .rx_ready_o(rx_ready_o), .tx_data_o(tx_data_o),
        .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i),
        .touch_i(touch_i), .nvm_fault_i(nvm_fault_i), .hid_type_o(hid),
        .touch_en_o(ten), .cal_active_o(cact), .cal_type_o(ctyp));
    tcc_host_sink host_u (.mclk_i(mclk_i), .rst_i(rst_i),
        .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o),
        .tx_ready_o(tx_ready_i), .got_o(got), .byte_o(gb));
    initial
        forever #10 mclk_i = !mclk_i;
    always @(negedge mclk_i)
        if (got === 1'b1) rxq.push_back(gb);
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic int ofs(input tcc_b_t c);
        return (c == 8'h21 || c == 8'h20) ? 0 : 16;
    endfunction : ofs
    task automatic conclude;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude
    task automatic tmo;
        miscompares++;
        conclude();
    endtask : tmo
    task automatic chk(input string nm, input tcc_b_t e, input tcc_b_t g);
        comparisons++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chk
    task automatic snd(input tcc_b_t p[$]);
        logic r;
        foreach (p[i])
        begin
            @(negedge mclk_i);
            rx_data_i = p[i];
            rx_valid_i = 1'b1;
            r = 1'b0;
            for (int k = 0; k < 600 && !r; k++)
            begin
                r = rx_ready_o;
                @(posedge mclk_i);
                if (!r) @(negedge mclk_i);
            end
            if (!r) tmo();
        end
        @(negedge mclk_i);
        rx_valid_i = 1'b0;
    endtask : snd
    task automatic exp(input string nm, input tcc_b_t p[$]);
        int k;
        foreach (p[i])
        begin
            for (k = 0; k < 600 && rxq.size() == 0; k++) @(negedge mclk_i);
            if (rxq.size() == 0) tmo();
            chk(nm, p[i], rxq.pop_front());
        end
    endtask : exp
    task automatic wr(input tcc_b_t c, input tcc_b_t a, input int n);
        tcc_b_t p[$];
        p = {8'h55, 8'(n + 3), c, 8'h00, a};
        for (int i = 0; i < n; i++)
        begin
            seed = lfsr(seed);
            p.push_back(seed[7:0]);
            mdl[ofs(c) + a + i] = seed[7:0];
        end
        snd(p);
        exp("store reply", {8'h55, 8'h02, 8'h00, c});
    endtask : wr
    task automatic rd(input tcc_b_t c, input tcc_b_t a, input int n);
        tcc_b_t p[$];
        snd({8'h55, 8'h04, c, 8'h00, a, 8'(n)});
        p = {8'h55, 8'(n + 2), 8'h00, c};
        for (int i = 0; i < n; i++) p.push_back(mdl[ofs(c) + a + i]);
        exp("fetch reply", p);
    endtask : rd
    task automatic quiet(input string nm);
        repeat (30) @(negedge mclk_i);
        chk(nm, 8'h00, 8'(rxq.size()));
    endtask : quiet
    initial
    begin
        foreach (mdl[i]) mdl[i] = 8'h00;
        repeat (2) @(posedge mclk_i);
        @(negedge mclk_i);
        rst_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        wr(8'h21, 8'h0c, 4);
        rd(8'h20, 8'h0c, 4);
        wr(8'h29, 8'h1e, 2);
        rd(8'h28, 8'h1e, 2);
        for (int j = 0; j < 3; j++)
        begin
            seed = lfsr(seed);
            wr(8'h21, {5'h00, seed[2:0]}, 1 + seed[10:8]);
            rd(8'h20, 8'h00, 16);
        end
        snd({8'h55, 8'h01, 8'h2b});
        exp("save reply", {8'h55, 8'h02, 8'h00, 8'h2b});
        for (int i = 0; i < 16; i++) mdl[16 + i] = mdl[i];
        rd(8'h28, 8'h00, 16);
        wr(8'h21, 8'h00, 3);
        snd({8'h55, 8'h01, 8'h23});
        exp("load reply", {8'h55, 8'h02, 8'h00, 8'h23});
        for (int i = 0; i < 16; i++) mdl[i] = mdl[16 + i];
        rd(8'h20, 8'h00, 16);
        nvm_fault_i = 1'b1;
        snd({8'h55, 8'h01, 8'h23});
        exp("load fail", {8'h55, 8'h02, 8'h05, 8'h23});
        nvm_fault_i = 1'b0;
        snd({8'h55, 8'h01, 8'h30});
        exp("unknown", {8'h55, 8'h02, 8'h01, 8'h30});
        snd({8'h55, 8'h05, 8'h20, 8'h00, 8'h00, 8'h02, 8'h00});
        exp("bad size", {8'h55, 8'h02, 8'h01, 8'h20});
        rd(8'h20, 8'h00, 16);
        snd({8'h55, 8'h01, 8'h12});
        exp("enable", {8'h55, 8'h02, 8'h00, 8'h12});
        chk("touch enable", 8'h01, {7'h00, ten});
        snd({8'h55, 8'h01, 8'h13});
        exp("disable", {8'h55, 8'h02, 8'h00, 8'h13});
        chk("touch enable", 8'h00, {7'h00, ten});
        snd({8'h55, 8'h01, 8'h12});
        exp("enable", {8'h55, 8'h02, 8'h00, 8'h12});
        for (int t = 1; t < 5; t++)
        begin
            snd({8'h55, 8'h02, 8'h14, 8'(t)});
            repeat (3) @(negedge mclk_i);
            chk("cal type", 8'(t), {5'h00, ctyp});
            chk("cal busy", 8'h01, {7'h00, cact});
            touch_i = 1'b1;
            repeat (8) @(negedge mclk_i);
            touch_i = 1'b0;
            exp("cal point", {8'h55, 8'h02, 8'h00, 8'h14});
            snd({8'h00});
            exp("cal cancel", {8'h55, 8'h02, 8'hfc, 8'h14});
            repeat (3) @(negedge mclk_i);
            chk("cal busy", 8'h00, {7'h00, cact});
        end
        snd({8'h55, 8'h04, 8'h20});
        exp("timeout", {8'h55, 8'h02, 8'h04, 8'h20});
        snd({8'h55, 8'h01, 8'h71});
        quiet("select reply");
        chk("hid type", 8'h01, {6'h00, hid});
        snd({8'h55, 8'h04, 8'h20, 8'h00, 8'h00, 8'h01});
        quiet("pointer fetch");
        snd({8'h55, 8'h01, 8'h72});
        quiet("select reply");
        chk("hid type", 8'h02, {6'h00, hid});
        snd({8'h55, 8'h01, 8'h70});
        quiet("select reply");
        chk("hid type", 8'h00, {6'h00, hid});
        rd(8'h20, 8'h00, 2);
        conclude();
    end
endmodule : tb
`default_nettype wire
